// File: pkg/scm_map.vh
`ifndef SCM_MAP_VH
`define SCM_MAP_VH

// register byte addresses
`define SCM_ADDR_W 8
`define SCM_ADDR_CLK_SEL 8'h00
`define SCM_ADDR_FAST_OSC 8'h04

// system_clock_select fields
`define SCM_SEL_HI 7
`define SCM_SEL_LO 5
`define SCM_HKEEP_BIT 1
`define SCM_LKEEP_BIT 0
`define SCM_SEL_RST 3'h0
`define SCM_HKEEP_RST 1'h0
`define SCM_LKEEP_RST 1'h0
`define SCM_SEL_SUB 3'h7
`define SCM_SEL_DIV1 3'h0

// fast_oscillator_control fields
`define SCM_FREQ_HI 3
`define SCM_FREQ_LO 2
`define SCM_STABLE_BIT 1
`define SCM_EN_BIT 0
`define SCM_FREQ_RST 2'h0
`define SCM_EN_RST 1'h1
`define SCM_STABLE_RST 1'h0

// least settle wait before the ready pin is trusted, 100 ns at 20 ns pclk
`define SCM_SETTLE_W 4
`define SCM_SETTLE_CYC 4'h5

// divider counter
`define SCM_DIV_W 6

// operating mode codes
`define SCM_MODE_FAST 3'h0
`define SCM_MODE_SLOW 3'h1
`define SCM_MODE_IDLE_LOW 3'h2
`define SCM_MODE_IDLE_BOTH 3'h3
`define SCM_MODE_IDLE_HIGH 3'h4
`define SCM_MODE_SLEEP 3'h5

`endif

// File: rtl/scm_sync.v
`timescale 1ns/1ps
// three-stage synchroniser, output moves once stages two and three agree
module scm_sync (
  input wire pclk,
  input wire presetn,
  input wire d,
  output reg q_r
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_r <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end

endmodule // scm_sync

// File: rtl/scm_top.v
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "scm_map.vh"

module scm_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SCM_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire halt_req,
  input wire wake_req,
  input wire watchdog_en,
  input wire hs_clk_pin,
  input wire sub_clk_pin,
  input wire fast_osc_ready_pin,
  input wire slow_osc_ready_pin,
  output reg fast_osc_run,
  output reg [1:0] fast_osc_freq,
  output reg [1:0] fast_freq_applied,
  output reg slow_osc_run,
  output reg sys_clk,
  output reg cpu_clk_en,
  output reg high_clk_periph_en,
  output reg sub_clk_periph_en,
  output reg [2:0] op_mode
);

  localparam ST_RUN = 1'b0;
  localparam ST_HALT = 1'b1;

  // register state
  reg [2:0] sel_r;
  reg hkeep_r;
  reg lkeep_r;
  reg en_r;
  reg stable_r;
  reg pend_r;
  reg [`SCM_SETTLE_W-1:0] settle_r;
  reg state_r;
  reg state_nxt;
  reg [2:0] act_sel_r;
  reg [`SCM_DIV_W-1:0] div_cnt_r;
  reg skip_r;
  reg hs_prev_r;
  reg sub_prev_r;

  wire hs_q;
  wire sub_q;
  wire fast_rdy_q;
  wire slow_rdy_q;

  // oscillator inputs from the analog side
  scm_sync u_sync_hs (
    .pclk(pclk),
    .presetn(presetn),
    .d(hs_clk_pin),
    .q_r(hs_q)
  );

  scm_sync u_sync_sub (
    .pclk(pclk),
    .presetn(presetn),
    .d(sub_clk_pin),
    .q_r(sub_q)
  );

  scm_sync u_sync_frdy (
    .pclk(pclk),
    .presetn(presetn),
    .d(fast_osc_ready_pin),
    .q_r(fast_rdy_q)
  );

  scm_sync u_sync_srdy (
    .pclk(pclk),
    .presetn(presetn),
    .d(slow_osc_ready_pin),
    .q_r(slow_rdy_q)
  );

  // apb decode
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire hit_sel = (paddr == `SCM_ADDR_CLK_SEL);
  wire hit_osc = (paddr == `SCM_ADDR_FAST_OSC);
  wire wr_sel = access & pwrite & hit_sel;
  wire wr_osc = access & pwrite & hit_osc;

  wire [1:0] freq_new = pwdata[`SCM_FREQ_HI:`SCM_FREQ_LO];
  wire en_new = pwdata[`SCM_EN_BIT];

  wire [7:0] sel_view = {sel_r, 3'h0, hkeep_r, lkeep_r};
  wire [7:0] osc_view = {4'h0, fast_osc_freq, stable_r, en_r};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~(hit_sel | hit_osc);
      if (setup) begin
        if (hit_sel) begin
          prdata <= {24'h00_0000, sel_view};
        end else if (hit_osc) begin
          prdata <= {24'h00_0000, osc_view};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= `SCM_SEL_RST;
      hkeep_r <= `SCM_HKEEP_RST;
      lkeep_r <= `SCM_LKEEP_RST;
      fast_osc_freq <= `SCM_FREQ_RST;
      en_r <= `SCM_EN_RST;
    end else begin
      if (wr_sel) begin
        sel_r <= pwdata[`SCM_SEL_HI:`SCM_SEL_LO];
        hkeep_r <= pwdata[`SCM_HKEEP_BIT];
        lkeep_r <= pwdata[`SCM_LKEEP_BIT];
      end
      if (wr_osc) begin
        fast_osc_freq <= freq_new;
        en_r <= en_new;
      end
    end
  end

  // halt state machine
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (halt_req) begin
          state_nxt = ST_HALT;
        end
      end
      ST_HALT: begin
        if (wake_req) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  wire halt_nxt = (state_nxt == ST_HALT);

  wire fast_run_nxt = en_r & (~halt_nxt | hkeep_r);
  wire slow_run_nxt = ~halt_nxt | lkeep_r | watchdog_en;

  wire fast_ok = stable_r & fast_osc_run;
  wire slow_ok = slow_rdy_q & slow_osc_run;

  // restart on enable, wake or frequency change
  wire freq_chg = wr_osc & en_new & (freq_new != fast_osc_freq);
  wire restart = (fast_run_nxt & ~fast_osc_run) | freq_chg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_r <= `SCM_STABLE_RST;
      pend_r <= 1'b1;
      settle_r <= `SCM_SETTLE_CYC;
      fast_freq_applied <= `SCM_FREQ_RST;
    end else if (restart) begin
      stable_r <= 1'b0;
      pend_r <= 1'b1;
      settle_r <= `SCM_SETTLE_CYC;
    end else if (!fast_osc_run) begin
      stable_r <= 1'b0;
      pend_r <= 1'b0;
    end else if (pend_r) begin
      if (settle_r != {`SCM_SETTLE_W{1'b0}}) begin
        settle_r <= settle_r - 1'b1;
      end else if (fast_rdy_q) begin
        stable_r <= 1'b1;
        pend_r <= 1'b0;
        fast_freq_applied <= fast_osc_freq;
      end
    end
  end

  // edges of the synchronised source clocks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_prev_r <= 1'b0;
      sub_prev_r <= 1'b0;
    end else begin
      hs_prev_r <= hs_q;
      sub_prev_r <= sub_q;
    end
  end

  wire hs_edge = hs_q ^ hs_prev_r;
  wire sub_edge = sub_q ^ sub_prev_r;

  // half period in source edges minus one
  function [`SCM_DIV_W-1:0] half_term;
    input [2:0] code;
    begin
      case (code)
        3'h0: half_term = 6'h00;
        3'h1: half_term = 6'h01;
        3'h2: half_term = 6'h03;
        3'h3: half_term = 6'h07;
        3'h4: half_term = 6'h0F;
        3'h5: half_term = 6'h1F;
        3'h6: half_term = 6'h3F;
        default: half_term = 6'h00;
      endcase
    end
  endfunction

  // fast source from fast rc, sub from slow rc
  wire act_sub = (act_sel_r == `SCM_SEL_SUB);
  wire src_ok = act_sub ? slow_ok : fast_ok;
  wire src_edge = act_sub ? (sub_edge & slow_ok) : (hs_edge & fast_ok);
  // first edge after a switch only arms the divider
  // so the first phase of the new source is never cut short
  wire tick = src_edge & ~skip_r;
  wire at_term = (div_cnt_r == half_term(act_sel_r));
  wire toggle = tick & at_term;

  // sub target waits for slow oscillator
  // fast target waits for stable flag
  wire tgt_sub = (sel_r == `SCM_SEL_SUB);
  wire tgt_ok = tgt_sub ? slow_ok : fast_ok;
  wire want = (sel_r != act_sel_r);

  // switch at the end of a full high phase, or while sys_clk is low and the current source is not ok
  wire sw_edge = toggle & sys_clk;
  wire sw_idle = ~sys_clk & ~src_ok;
  wire do_switch = want & tgt_ok & (sw_edge | sw_idle);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sel_r <= `SCM_SEL_DIV1;
      div_cnt_r <= {`SCM_DIV_W{1'b0}};
      sys_clk <= 1'b0;
      skip_r <= 1'b0;
    end else if (do_switch) begin
      act_sel_r <= sel_r;
      div_cnt_r <= {`SCM_DIV_W{1'b0}};
      sys_clk <= 1'b0;
      skip_r <= 1'b1;
    end else if (src_edge & skip_r) begin
      skip_r <= 1'b0;
    end else if (toggle) begin
      div_cnt_r <= {`SCM_DIV_W{1'b0}};
      sys_clk <= ~sys_clk;
    end else if (tick) begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  // mode and clock gating outputs
  reg [2:0] mode_nxt;

  always @* begin
    mode_nxt = `SCM_MODE_FAST;
    if (!halt_nxt) begin
      if (act_sub) begin
        mode_nxt = `SCM_MODE_SLOW;
      end else begin
        mode_nxt = `SCM_MODE_FAST;
      end
    end else begin
      // sleep when both keep bits clear
      case ({hkeep_r, lkeep_r})
        2'h1: mode_nxt = `SCM_MODE_IDLE_LOW;
        2'h3: mode_nxt = `SCM_MODE_IDLE_BOTH;
        2'h2: mode_nxt = `SCM_MODE_IDLE_HIGH;
        default: mode_nxt = `SCM_MODE_SLEEP;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_osc_run <= `SCM_EN_RST;
      slow_osc_run <= 1'b1;
      cpu_clk_en <= 1'b1;
      high_clk_periph_en <= 1'b0;
      sub_clk_periph_en <= 1'b0;
      op_mode <= `SCM_MODE_FAST;
    end else begin
      fast_osc_run <= fast_run_nxt;
      slow_osc_run <= slow_run_nxt;
      cpu_clk_en <= ~halt_nxt;
      high_clk_periph_en <= fast_run_nxt & stable_r;
      sub_clk_periph_en <= (~halt_nxt | lkeep_r) & slow_ok;
      op_mode <= mode_nxt;
    end
  end

endmodule // scm_top

// File: verification/scm_asserts.sv
`timescale 1ns/1ps
module scm_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire watchdog_en,
  input wire halt_req,
  input wire fast_osc_run,
  input wire [1:0] fast_osc_freq,
  input wire [1:0] fast_freq_applied,
  input wire slow_osc_run,
  input wire sys_clk,
  input wire cpu_clk_en,
  input wire [2:0] op_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_fast;
    psel && penable && pready && pwrite && paddr == 8'h04;
  endsequence
  a_ready_after_setup: assert property (
    s_setup |=> pready) else $error("no ready after setup");
  a_err_unmapped: assert property (
    pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04))
    else $error("error flag wrong");
  a_pad_zero: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h0
    && (paddr != 8'h00 || prdata[4:2] == 3'h0)
    && (paddr != 8'h04 || prdata[7:4] == 4'h0))
    else $error("unused bits not zero");
  a_freq_follow: assert property (
    s_wr_fast |=> fast_osc_freq == $past(pwdata[3:2]))
    else $error("freq field not followed");
  a_freq_enable: assert property (
    s_wr_fast ##1 cpu_clk_en ##1 cpu_clk_en
    |-> fast_osc_run == $past(pwdata[0], 2)) else $error("run wrong");
  a_no_glitch: assert property (
    $changed(sys_clk) |=> $stable(sys_clk) [*2])
    else $error("system clock phase too short");
  a_applied_load: assert property (
    $changed(fast_freq_applied) |-> fast_freq_applied == fast_osc_freq)
    else $error("applied freq wrong");
  a_halt_stops: assert property (
    cpu_clk_en && halt_req |=> !cpu_clk_en && op_mode >= 3'h2)
    else $error("halt not taken");
  a_mode_cpu: assert property (
    cpu_clk_en == (op_mode < 3'h2)) else $error("cpu enable vs mode");
  a_idle_fast: assert property (
    op_mode inside {3'h3, 3'h4} |-> fast_osc_run)
    else $error("fast osc stopped in idle");
  a_fast_off: assert property (
    op_mode inside {3'h2, 3'h5} |-> !fast_osc_run)
    else $error("fast osc runs in halt");
  a_sleep_wdog: assert property (
    (op_mode == 3'h5 && watchdog_en) [*2] |-> slow_osc_run)
    else $error("slow osc off with watchdog");
  a_slow_keep: assert property (
    (op_mode == 3'h4 && !watchdog_en) [*2] |-> !slow_osc_run)
    else $error("slow osc not stopped");
endmodule // scm_asserts

bind scm_top scm_asserts chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .watchdog_en(watchdog_en),
  .halt_req(halt_req), .fast_osc_run(fast_osc_run),
  .fast_osc_freq(fast_osc_freq), .fast_freq_applied(fast_freq_applied),
  .slow_osc_run(slow_osc_run), .cpu_clk_en(cpu_clk_en), .op_mode(op_mode),
  .sys_clk(sys_clk)
);

// File: verification/system_clock_mode_control_bench.sv
`timescale 1ns/1ps
module system_clock_mode_control_bench;
  logic pclk, presetn, psel, penable, pwrite, halt_req, wake_req;
  logic watchdog_en, hs_clk_pin, sub_clk_pin, fr_pin, sr_pin, err;
  logic [7:0] paddr;
  logic [7:0] cnt = 8'h00;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, fast_osc_run, slow_osc_run, sys_clk, cpu_clk_en;
  wire high_clk_periph_en, sub_clk_periph_en;
  wire [1:0] fast_osc_freq, fast_freq_applied;
  wire [2:0] op_mode;
  int failures, n_checks;
  logic [2:0] md [4] = '{3'h5, 3'h2, 3'h4, 3'h3};
  logic [2:0] cs [5] = '{3'h7, 3'h1, 3'h0, 3'h2, 3'h3};
  int rs [5] = '{4, 8, 16, 4, 2};

  scm_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_req(halt_req),
    .wake_req(wake_req), .watchdog_en(watchdog_en),
    .hs_clk_pin(hs_clk_pin), .sub_clk_pin(sub_clk_pin),
    .fast_osc_ready_pin(fr_pin), .slow_osc_ready_pin(sr_pin),
    .fast_osc_run(fast_osc_run), .fast_osc_freq(fast_osc_freq),
    .fast_freq_applied(fast_freq_applied), .slow_osc_run(slow_osc_run),
    .sys_clk(sys_clk), .cpu_clk_en(cpu_clk_en),
    .high_clk_periph_en(high_clk_periph_en),
    .sub_clk_periph_en(sub_clk_periph_en), .op_mode(op_mode)
  );

  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end

  // slow oscillators: fast edge every 4 cycles, sub every 16
  always @(posedge pclk) begin
    cnt <= cnt + 8'h01;
    hs_clk_pin <= cnt[2];
    sub_clk_pin <= cnt[4];
    fr_pin <= fast_osc_run;
    sr_pin <= slow_osc_run;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %0t no ready from slave", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task wait_flag;
    int n;
    n = 0;
    apb(0, 8'h04, 0);
    while (rd[1] !== 1'b1 && n < 40) begin
      n++;
      apb(0, 8'h04, 0);
    end
    if (rd[1] !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %0t stable flag never set", $time);
    end
  endtask

  task t_regs;
    apb(0, 8'h00, 0);
    chk(rd, 32'h0);
    apb(0, 8'h04, 0);
    chk(rd, 32'h1);
    wait_flag;
    chk(rd, 32'h3);
    apb(1, 8'h00, 32'hFF1F);
    apb(0, 8'h00, 0);
    chk(rd, 32'h3);
    apb(1, 8'h04, 32'hF0);
    // flag drops once the stopped oscillator is seen
    repeat (2) @(posedge pclk);
    apb(0, 8'h04, 0);
    chk(rd, 32'h0);
    chk(fast_osc_run, 0);
    apb(1, 8'h08, 32'hFF);
    chk(err, 1);
    apb(0, 8'h08, 0);
    chk(rd, 0);
    apb(1, 8'h04, 32'h1);
    wait_flag;
    chk(fast_osc_run, 1);
  endtask

  task t_freq;
    logic [1:0] f;
    for (int i = 1; i < 5; i++) begin
      f = i[1:0];
      apb(1, 8'h04, {28'h0, f, 2'b01});
      apb(0, 8'h04, 0);
      chk(rd, {28'h0, f, 2'b01});
      wait_flag;
      chk(fast_osc_freq, f);
      chk(fast_freq_applied, f);
    end
  endtask

  task halt_chk(input logic [2:0] m, input logic fr, input logic sr);
    @(posedge pclk) halt_req <= 1;
    @(posedge pclk) halt_req <= 0;
    #1 chk(op_mode, m);
    chk(cpu_clk_en, 0);
    chk(fast_osc_run, fr);
    chk(slow_osc_run, sr);
    chk(high_clk_periph_en, m == 3'h3 || m == 3'h4);
    chk(sub_clk_periph_en, m == 3'h2 || m == 3'h3);
    @(posedge pclk) wake_req <= 1;
    @(posedge pclk) wake_req <= 0;
    #1 chk(op_mode, 0);
    chk(cpu_clk_en, 1);
    wait_flag;
    chk(rd[1], 1);
  endtask

  task t_halt;
    for (int k = 0; k < 4; k++) begin
      apb(1, 8'h00, k);
      halt_chk(md[k], k[1], k[0]);
    end
    @(posedge pclk) watchdog_en <= 1;
    apb(1, 8'h00, 0);
    halt_chk(3'h5, 0, 1);
  endtask

  // count sys_clk rises over a 128-cycle window per select code
  task t_switch;
    int n;
    logic p;
    for (int i = 0; i < 5; i++) begin
      apb(1, 8'h00, {24'h0, cs[i], 5'h0});
      repeat (128) @(posedge pclk);
      n = 0;
      p = sys_clk;
      repeat (128) begin
        @(posedge pclk);
        if (sys_clk && !p) n++;
        p = sys_clk;
      end
      chk(n, rs[i]);
      chk(op_mode, cs[i] == 3'h7);
    end
  endtask

  task complete_run;
    $display("failures=%0d n_checks=%0d", failures, n_checks);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    complete_run;
  end

  initial begin
    {psel, penable, pwrite, halt_req, wake_req, watchdog_en} = 0;
    presetn = 0;
    paddr = 0;
    pwdata = 0;
    failures = 0;
    n_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_freq;
    t_halt;
    t_switch;
    complete_run;
  end
endmodule // system_clock_mode_control_bench
